// ---- rtl/cbl_loader.sv ----
// Serial configuration loader with chain forwarding.
module cbl_loader
    import cbl_pkg::*;
#(
    parameter int unsigned FRAME_BITS = 64,  // Data bits per frame.
    parameter int unsigned FRAMES     = 8    // Frames this device needs.
)
(
    // Clock and reset.
    input  wire logic             SYS_CLK,
    input  wire logic             RESETN,
    // Static options, from pins.
    input  wire logic             MASTER_MODE,
    input  wire logic             CRC_SELECT,
    // Configuration clock pin, split into its three signals.
    input  wire logic             CONFIG_CLOCK_I,
    output logic                  CONFIG_CLOCK_O,
    output logic                  CONFIG_CLOCK_OE,
    // Serial data in and daisy-chain data out.
    input  wire logic             DATA_IN,
    output logic                  DOUT,
    // Open-drain init error line.
    output logic                  INIT_N_O,
    output logic                  INIT_N_OE,
    // Assembled bytes.
    output logic [7:0]            BYTE_DATA,
    output logic                  BYTE_VALID,
    // Start-up status.
    output logic [cbl_pkg::LEN_W-1:0] LENGTH_COUNT,
    output logic                  DONE,
    output logic                  USER_IO_EN,
    output logic                  READBACK_OK,
    output logic                  SCAN_OK,
    output logic                  FAST_CLOCK
);

    localparam int unsigned CNT_W = 16;

    // Synchroniser chains: bit 0 is the first stage.
    logic [2:0]       clk_sync_reg;  // Configuration clock pin.
    logic [2:0]       dat_sync_reg;  // Data pin.
    logic [2:0]       mst_sync_reg;  // Master mode pin.
    logic [2:0]       crc_sync_reg;  // CRC option pin.
    logic             clk_filt_reg;  // Accepted clock level.
    logic             dat_filt_reg;  // Accepted data level.
    logic             mst_filt_reg;  // Accepted master mode.
    logic             crc_filt_reg;  // Accepted CRC option.

    // Divider for the master clock.
    logic [DIV_W-1:0] div_reg;       // Half-period counter.
    logic             mclk_reg;      // Internally made clock level.

    // Edge enables of the configuration clock.
    logic             config_clock_rise;     // Rising edge this cycle.
    logic             config_clock_fall;     // Falling edge this cycle.
    logic             slave_rise;    // Rising edge seen on the pin.
    logic             slave_fall;    // Falling edge seen on the pin.
    logic             m_toggle;      // Divider wraps this cycle.

    // Parser.
    cbl_state_t         state_reg;   // Parser state.
    cbl_state_t         state_next;  // Its next value.
    logic [11:0]        hdr_reg;     // Last twelve received bits.
    logic [LEN_W-1:0]   len_reg;     // Length count shift register.
    logic               len_ok_reg;  // Length count captured.
    logic [CNT_W-1:0]   bit_cnt_reg; // Bit counter within a field.
    logic [CNT_W-1:0]   frm_cnt_reg; // Frames absorbed before the final one.
    logic [LAST_CHECK_W-1:0] chk_reg; // Received check bits.
    logic               fwd_reg;     // Bit to present at the next fall.
    logic               fast_reg;    // Fast master clock chosen.
    logic               rx_bit;      // Bit sampled at this rise.
    logic               last_frame;  // Current frame is the final one.
    logic               hold_last;   // Data bit belongs to the final check.
    logic               crc_shift;   // Feed the CRC this rise.
    logic               check_pass;  // Check field matches.
    logic [CRC_W-1:0]   crc_val;     // Running CRC.

    // Byte assembly.
    logic [7:0]         byte_reg;    // Byte being assembled.
    logic [2:0]         byte_cnt_reg;// Bits in the current byte.

    // Start-up.
    logic [LEN_W-1:0]   config_clock_cnt_reg;// Rising clocks since initialisation.
    logic               match_reg;   // Length count matched.
    logic [2:0]         su_cnt_reg;  // Rising clocks since the match.

    // Field end test, used by several states.
    function automatic logic field_end(input logic [CNT_W-1:0] cnt, input int unsigned len);
        field_end = (cnt == CNT_W'(len - 1));
    endfunction

    // Three-stage synchronisers; stages two and three must agree.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            clk_sync_reg <= 3'h0;
            dat_sync_reg <= 3'h7;
            mst_sync_reg <= 3'h0;
            crc_sync_reg <= 3'h0;
            clk_filt_reg <= 1'b0;
            dat_filt_reg <= 1'b1;
            mst_filt_reg <= 1'b0;
            crc_filt_reg <= 1'b0;
        end
        else
        begin
            clk_sync_reg <= {clk_sync_reg[1:0], CONFIG_CLOCK_I};
            dat_sync_reg <= {dat_sync_reg[1:0], DATA_IN};
            mst_sync_reg <= {mst_sync_reg[1:0], MASTER_MODE};
            crc_sync_reg <= {crc_sync_reg[1:0], CRC_SELECT};
            if (clk_sync_reg[1] == clk_sync_reg[2])
            begin
                clk_filt_reg <= clk_sync_reg[2];
            end
            if (dat_sync_reg[1] == dat_sync_reg[2])
            begin
                dat_filt_reg <= dat_sync_reg[2];
            end
            if (mst_sync_reg[1] == mst_sync_reg[2])
            begin
                mst_filt_reg <= mst_sync_reg[2];
            end
            if (crc_sync_reg[1] == crc_sync_reg[2])
            begin
                crc_filt_reg <= crc_sync_reg[2];
            end
        end
    end

    // Pin edges are taken from the agreed stages, never from the first.
    assign slave_rise = clk_sync_reg[1] & clk_sync_reg[2] & ~clk_filt_reg;
    assign slave_fall = ~clk_sync_reg[1] & ~clk_sync_reg[2] & clk_filt_reg;

    // The divider wraps after a half period; at or above also covers a slow-to-fast switch.
    assign m_toggle = fast_reg ? (div_reg >= DIV_W'(FAST_HALF - 1))
                               : (div_reg >= DIV_W'(SLOW_HALF - 1));

    // Master clock divider; runs on after an error.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div_reg  <= '0;
            mclk_reg <= 1'b0;
        end
        else if (m_toggle)
        begin
            div_reg  <= '0; // R9 R10 R21
            mclk_reg <= ~mclk_reg;
        end
        else
        begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    // Master mode: the internal clock paces the loader.
    assign config_clock_rise = mst_filt_reg ? (m_toggle & ~mclk_reg) : slave_rise;
    assign config_clock_fall = mst_filt_reg ? (m_toggle & mclk_reg) : slave_fall;
    assign rx_bit    = dat_filt_reg;

    // Clock pin drive; the master keeps driving whatever the parser does.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CONFIG_CLOCK_O  <= 1'b0;
            CONFIG_CLOCK_OE <= 1'b0;
        end
        else
        begin
            CONFIG_CLOCK_O  <= mclk_reg; // R21
            CONFIG_CLOCK_OE <= mst_filt_reg;
        end
    end

    // Frame bookkeeping shared by the parser and the CRC feed.
    assign last_frame = (frm_cnt_reg == CNT_W'(FRAMES - 1));
    assign hold_last  = last_frame & crc_filt_reg &
                        (bit_cnt_reg >= CNT_W'(FRAME_BITS - LAST_DATA_BITS));
    assign crc_shift  = config_clock_rise & (state_reg == ST_DATA) & ~hold_last;

    // Check compare at the last check rise; the bit arriving now is included.
    always_comb
    begin
        if (!crc_filt_reg)
        begin
            check_pass = ({chk_reg[2:0], rx_bit} == CONST_CHECK); // R18
        end
        else if (last_frame)
        begin
            check_pass = ({chk_reg[LAST_CHECK_W-2:0], rx_bit} == crc_val[LAST_CHECK_W-1:0]); // R19
        end
        else
        begin
            check_pass = ({chk_reg[2:0], rx_bit} == crc_val[3:0]); // R18
        end
    end

    // Parser next state; one layout whatever the mode.
    always_comb
    begin
        state_next = state_reg; // R12
        unique case (state_reg)
            ST_HUNT:
            begin
                if (config_clock_rise && {hdr_reg[10:0], rx_bit} == HEADER_PATTERN)
                begin
                    state_next = ST_LEN; // R1 R13
                end
            end
            ST_LEN:
            begin
                if (config_clock_rise && field_end(bit_cnt_reg, LEN_W))
                begin
                    state_next = ST_SEP; // R13
                end
            end
            ST_SEP:
            begin
                if (config_clock_rise && !rx_bit)
                begin
                    state_next = ST_ERROR; // R13 R20
                end
                else if (config_clock_rise && field_end(bit_cnt_reg, SEP_BITS))
                begin
                    state_next = ST_START;
                end
            end
            ST_START:
            begin
                if (config_clock_rise)
                begin
                    state_next = rx_bit ? ST_ERROR : ST_DATA; // R14 R20
                end
            end
            ST_DATA:
            begin
                if (config_clock_rise && field_end(bit_cnt_reg, FRAME_BITS))
                begin
                    state_next = ST_CHECK; // R14
                end
            end
            ST_CHECK:
            begin
                if (config_clock_rise && field_end(bit_cnt_reg, CHECK_BITS))
                begin
                    if (!check_pass)
                    begin
                        state_next = ST_ERROR; // R20
                    end
                    else
                    begin
                        state_next = last_frame ? ST_POST : ST_START;
                    end
                end
            end
            ST_POST:
            begin
                if (config_clock_rise && field_end(bit_cnt_reg, POST_BITS))
                begin
                    state_next = ({hdr_reg[6:0], rx_bit} == POSTAMBLE) ? ST_PASS
                                                                      : ST_ERROR; // R15
                end
            end
            ST_PASS:
            begin
                state_next = ST_PASS; // R3
            end
            ST_ERROR:
            begin
                state_next = ST_ERROR; // R20
            end
            default:
            begin
                state_next = ST_ERROR;
            end
        endcase
    end

    // Parser state register.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_HUNT;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Bit history and counters, advanced on a rise.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            hdr_reg     <= '0;
            bit_cnt_reg <= '0;
            frm_cnt_reg <= '0;
        end
        else if (config_clock_rise)
        begin
            hdr_reg <= {hdr_reg[10:0], rx_bit}; // R23
            if (state_next != state_reg)
            begin
                bit_cnt_reg <= '0;
            end
            else
            begin
                bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
            end
            if (state_reg == ST_CHECK && state_next == ST_START)
            begin
                frm_cnt_reg <= frm_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Length count capture, most significant bit first.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            len_reg    <= '0;
            len_ok_reg <= 1'b0;
        end
        else if (config_clock_rise && state_reg == ST_LEN)
        begin
            len_reg <= {len_reg[LEN_W-2:0], rx_bit}; // R1
            if (field_end(bit_cnt_reg, LEN_W))
            begin
                len_ok_reg <= 1'b1;
            end
        end
    end

    // Check bits; the final CRC frame adds its last data bits.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            chk_reg <= '0;
        end
        else if (config_clock_rise && state_reg == ST_START)
        begin
            chk_reg <= '0;
        end
        else if (config_clock_rise && (state_reg == ST_CHECK || hold_last))
        begin
            chk_reg <= {chk_reg[LAST_CHECK_W-2:0], rx_bit}; // R19
        end
    end

    // First data bit of the first frame selects the fast clock.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fast_reg <= 1'b0; // R24 R9
        end
        else if (config_clock_rise && state_reg == ST_DATA && frm_cnt_reg == '0 && bit_cnt_reg == '0)
        begin
            fast_reg <= rx_bit; // R10 R24
        end
    end

    // Running CRC over the frame data bits.
    cbl_crc #(
        .WIDTH (CRC_W),
        .POLY  (CRC_POLY_DEF),
        .SEED  (CRC_SEED_DEF)
    ) u_crc (
        .clk      (SYS_CLK),
        .rst_n    (RESETN),
        .shift_en (crc_shift),
        .bit_in   (rx_bit),
        .crc      (crc_val)
    );

    // Forward choice at each rise.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fwd_reg <= 1'b1;
        end
        else if (config_clock_rise)
        begin
            if (state_reg == ST_HUNT || state_reg == ST_LEN)
            begin
                fwd_reg <= rx_bit; // R1
            end
            else if (state_reg == ST_PASS)
            begin
                fwd_reg <= rx_bit; // R3
            end
            else
            begin
                fwd_reg <= 1'b1; // R2
            end
        end
    end

    // Forwarded data is presented on the following fall.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            DOUT <= 1'b1;
        end
        else if (config_clock_fall)
        begin
            DOUT <= fwd_reg; // R23
        end
    end

    // Byte assembly; the earliest bit lands in lane zero.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            byte_reg     <= '0;
            byte_cnt_reg <= '0;
            BYTE_DATA    <= '0;
            BYTE_VALID   <= 1'b0;
        end
        else
        begin
            BYTE_VALID <= 1'b0;
            if (config_clock_rise)
            begin
                byte_reg     <= {rx_bit, byte_reg[7:1]}; // R17
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
                if (byte_cnt_reg == 3'h7)
                begin
                    BYTE_DATA  <= {rx_bit, byte_reg[7:1]}; // R17
                    BYTE_VALID <= 1'b1;
                end
            end
        end
    end

    // Clock count and start-up sequence.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            config_clock_cnt_reg <= '0;
            match_reg    <= 1'b0;
            su_cnt_reg   <= '0;
        end
        else if (config_clock_rise)
        begin
            config_clock_cnt_reg <= config_clock_cnt_reg + LEN_W'(1); // R4
            if (!match_reg && len_ok_reg && state_reg != ST_ERROR &&
                config_clock_cnt_reg + LEN_W'(1) == len_reg)
            begin
                match_reg <= 1'b1; // R4 R6
            end
            if (match_reg && su_cnt_reg != SU_FINISH_AT)
            begin
                su_cnt_reg <= su_cnt_reg + 3'h1; // R16 R6
            end
        end
    end

    // Status outputs; the done, user I/O, readback and scan flags follow the start-up count.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            DONE         <= 1'b0;
            USER_IO_EN   <= 1'b0;
            READBACK_OK  <= 1'b0;
            SCAN_OK      <= 1'b0;
            LENGTH_COUNT <= '0;
            FAST_CLOCK   <= 1'b0;
        end
        else
        begin
            DONE         <= match_reg && su_cnt_reg >= SU_DONE_AT;
            USER_IO_EN   <= match_reg && su_cnt_reg >= SU_IO_AT; // R5
            READBACK_OK  <= su_cnt_reg == SU_FINISH_AT; // R7
            SCAN_OK      <= su_cnt_reg == SU_FINISH_AT; // R7
            LENGTH_COUNT <= len_reg;
            FAST_CLOCK   <= fast_reg;
        end
    end

    // Init line pulled low from the cycle after the parser enters ST_ERROR until reset.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            INIT_N_O  <= 1'b0;
            INIT_N_OE <= 1'b0;
        end
        else
        begin
            INIT_N_O  <= 1'b0;
            INIT_N_OE <= (state_reg == ST_ERROR); // R20 R22
        end
    end

endmodule

// ---- shared/cbl_pkg.sv ----
// Function
// [R1] Detect preamble, capture length, forward header downstream.
// [R2] Drive output high until own frames absorbed.
// [R3] After own load, forward further bits downstream.
// [R4] Start up when clock count equals length.
// [R5] Enable user I/O two clocks after last bit.
// [R6] All devices match together; master keeps clocking.
// [R7] Unfinished start-up blocks readback and boundary scan.
// [R8] Older lead device adds one extra clock pulse.
// [R9] Slow master clock, 0.5 to 1.25 MHz, default.
// [R10] Option selects fast clock, 4 to 10 MHz.
// [R11] Master driving older slave uses slow clock.
// [R12] One stream layout for every mode.
// [R13] Header: fill ones, preamble, length, separator ones.
// [R14] Frame: zero start bit, data, four-bit check.
// [R15] Postamble byte ends one device's data.
// [R16] Trailing start-up bytes give four clocks, ignored.
// [R17] First serial bit of byte maps lane zero.
// [R18] Check constant field, or running CRC partial check.
// [R19] Last frame: 11-bit CRC with seven data bits.
// [R20] On check error stop loading, pull init low.
// [R21] Master keeps driving clock after an error.
// [R22] Controller watches init, restarts by reconfigure pulse.
// [R23] Sample on rising clock, forward on falling.
// [R24] Start slow, may go fast during first frame.
// [R25] CRC polynomial and seed are configurable.
package cbl_pkg;

    // System clock rate and the two master clock rates, in kHz.
    localparam int unsigned SYS_CLK_KHZ  = 100000;
    localparam int unsigned SLOW_CLK_KHZ = 1000;
    localparam int unsigned FAST_CLK_KHZ = 8000;
    // Half periods in system cycles, rounded down.
    localparam int unsigned SLOW_HALF = SYS_CLK_KHZ / (2 * SLOW_CLK_KHZ);
    localparam int unsigned FAST_HALF = SYS_CLK_KHZ / (2 * FAST_CLK_KHZ);
    localparam int unsigned DIV_W     = 8;

    // Header layout: eight fill ones followed by the preamble code.
    localparam logic [11:0] HEADER_PATTERN = 12'hff2;
    localparam int unsigned LEN_W          = 24;
    localparam int unsigned SEP_BITS       = 4;
    localparam int unsigned CHECK_BITS     = 4;
    localparam int unsigned LAST_CHECK_W   = 11;
    localparam int unsigned LAST_DATA_BITS = 7;
    localparam logic [3:0]  CONST_CHECK    = 4'h6;
    localparam logic [7:0]  POSTAMBLE      = 8'h7f;
    localparam int unsigned POST_BITS      = 8;

    // Start-up points counted in rising clocks after the length match.
    localparam logic [2:0] SU_DONE_AT   = 3'h1;
    localparam logic [2:0] SU_IO_AT     = 3'h2;
    localparam logic [2:0] SU_FINISH_AT = 3'h4;

    // CRC defaults.
    localparam int unsigned CRC_W        = 16;
    localparam logic [15:0] CRC_POLY_DEF = 16'h8005;
    localparam logic [15:0] CRC_SEED_DEF = 16'h0000;

    // Parser states, one-hot.
    typedef enum logic [10:0] {
        ST_HUNT   = 11'h001,
        ST_LEN    = 11'h002,
        ST_SEP    = 11'h004,
        ST_START  = 11'h008,
        ST_DATA   = 11'h010,
        ST_CHECK  = 11'h020,
        ST_POST   = 11'h040,
        ST_PASS   = 11'h080,
        ST_ERROR  = 11'h100,
        ST_SPARE0 = 11'h200,
        ST_SPARE1 = 11'h400
    } cbl_state_t;

endpackage

// ---- rtl/cbl_crc.sv ----
// Serial running CRC with a configurable polynomial and seed.
module cbl_crc
#(
    parameter int unsigned          WIDTH = cbl_pkg::CRC_W,
    parameter logic [WIDTH-1:0]     POLY  = cbl_pkg::CRC_POLY_DEF,
    parameter logic [WIDTH-1:0]     SEED  = cbl_pkg::CRC_SEED_DEF
)
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Control.
    input  wire logic               shift_en,
    input  wire logic               bit_in,
    // Result.
    output logic [WIDTH-1:0]        crc
);
    import cbl_pkg::*;

    logic feedback; // Incoming bit folded with the register's top bit.

    assign feedback = bit_in ^ crc[WIDTH-1];

    // One LFSR step per accepted data bit; the seed is loaded at reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crc <= SEED; // R25
        end
        else if (shift_en)
        begin
            crc <= {crc[WIDTH-2:0], 1'b0} ^ (feedback ? POLY : '0); // R25
        end
    end

endmodule

// ---- verif/cbl_loader_assertions.sv ----
module cbl_loader_assertions
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Watched ports.
    input wire logic MASTER_MODE,
    input wire logic CONFIG_CLOCK_O,
    input wire logic CONFIG_CLOCK_OE,
    input wire logic DOUT,
    input wire logic INIT_N_O,
    input wire logic INIT_N_OE,
    input wire logic BYTE_VALID,
    input wire logic DONE,
    input wire logic USER_IO_EN,
    input wire logic READBACK_OK,
    input wire logic SCAN_OK,
    input wire logic FAST_CLOCK
);
    logic       prev_reg; // Master clock level one cycle ago.
    logic       seen_reg; // A master clock edge has been seen.
    logic [7:0] hold_reg; // Cycles the master clock level has held.
    default clocking dcb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);
    // Master clock level hold time.
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            prev_reg <= 1'b0;
            seen_reg <= 1'b0;
            hold_reg <= 8'h00;
        end
        else
        begin
            prev_reg <= CONFIG_CLOCK_O;
            seen_reg <= seen_reg | (CONFIG_CLOCK_O != prev_reg);
            hold_reg <= (CONFIG_CLOCK_O != prev_reg) ? 8'h01 : hold_reg + {7'h00, hold_reg != 8'hff};
        end
    end
    a_slow_half: assert property (seen_reg && !FAST_CLOCK && CONFIG_CLOCK_O != prev_reg
        |-> hold_reg == 8'h32) else $error("slow half period wrong");
    a_clock_alive: assert property (MASTER_MODE && seen_reg |-> hold_reg <= 8'h32)
        else $error("master clock stalled");
    a_slave_no_drive: assert property (!MASTER_MODE [*8] |=> !CONFIG_CLOCK_OE)
        else $error("slave drives clock pin");
    a_init_pull_low: assert property (INIT_N_OE |-> !INIT_N_O)
        else $error("init not pulled low");
    a_error_sticky: assert property ($rose(INIT_N_OE) |=> INIT_N_OE [*8])
        else $error("error flag dropped");
    a_error_dout_high: assert property (INIT_N_OE && DOUT |=> DOUT)
        else $error("output moved after error");
    a_done_sticky: assert property (DONE |=> DONE) else $error("done dropped");
    a_io_after_done: assert property (USER_IO_EN |-> DONE)
        else $error("io enabled before done");
    a_finish_pair: assert property (READBACK_OK |-> SCAN_OK && USER_IO_EN)
        else $error("finish flags out of step");
    a_byte_pulse: assert property (BYTE_VALID |=> !BYTE_VALID)
        else $error("byte strobe too long");
endmodule

bind cbl_loader cbl_loader_assertions u_chk (.*);

// ---- verif/cbl_stream_src.sv ----
// Upstream source: drives the link clock and serial data toward the loader.
module cbl_stream_src
(
    // Link clock and serial data.
    output logic link_clk,
    output logic link_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // The link clock stands still low outside transfers.
    initial
    begin
        link_clk = 1'b0;
        link_data = 1'b1;
    end
    // Data set at the fall, held across the rise.
    task automatic send_bit(input logic b);
        link_data = b;
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
    endtask
    // A released line shows the inverse of its last value.
    task automatic release_line();
        link_data = ~link_data;
    endtask
endmodule

// ---- verif/cbl_loader_tb.sv ----
module cbl_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cbl_pkg::*;
    localparam logic [23:0] LEN = 24'h000062; // Rises up to the match: 98.
    logic        sys_clk, resetn, master_mode, src_clk, src_data, config_clock_pin, config_clock_o, config_clock_oe;
    logic        dout, init_o, init_oe, byte_valid, done, io_en, rb_ok, scan_ok, fast;
    logic [7:0]  byte_data;
    logic [23:0] length_count;
    logic [7:0]  exp_q[$];
    int          miscompares = 0;
    int          tests_run = 0;
    int          flips[4] = '{36, 40, 78, 82};
    // The shared clock pin carries whichever party drives it.
    assign config_clock_pin = config_clock_oe ? config_clock_o : src_clk;
    cbl_stream_src src (.link_clk(src_clk), .link_data(src_data));
    cbl_loader #(.FRAME_BITS(16), .FRAMES(2)) dut (.SYS_CLK(sys_clk), .RESETN(resetn),
        .MASTER_MODE(master_mode), .CRC_SELECT(1'b0), .CONFIG_CLOCK_I(config_clock_pin),
        .CONFIG_CLOCK_O(config_clock_o), .CONFIG_CLOCK_OE(config_clock_oe), .DATA_IN(src_data), .DOUT(dout),
        .INIT_N_O(init_o), .INIT_N_OE(init_oe), .BYTE_DATA(byte_data), .BYTE_VALID(byte_valid),
        .LENGTH_COUNT(length_count), .DONE(done), .USER_IO_EN(io_en), .READBACK_OK(rb_ok),
        .SCAN_OK(scan_ok), .FAST_CLOCK(fast));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Compares each assembled byte with the oldest note.
    always @(negedge sys_clk)
    begin
        if (byte_valid === 1'b1 && exp_q.size() > 0)
            check("byte", 24'(exp_q.pop_front()), 24'(byte_data));
    end
    // Holds reset for six cycles with the chosen mode.
    task automatic do_reset(input logic m);
        resetn = 1'b0;
        master_mode = m;
        exp_q.delete();
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask
    // Sends one stream; a flip index >= 0 corrupts that bit.
    task automatic run(input int flip);
        logic        bits[$];
        logic [15:0] d;
        logic [7:0]  acc;
        logic        expd;
        int          i;
        acc = 8'h00;
        expd = 1'b1;
        for (i = 0; i < 40; i++)
            bits.push_back(i < 12 ? HEADER_PATTERN[11 - i] : (i < 36 ? LEN[35 - i] : 1'b1));
        repeat (2)
        begin
            d = 16'($urandom);
            bits.push_back(1'b0);
            for (i = 0; i < 20; i++)
                bits.push_back(i < 16 ? d[i] : CONST_CHECK[19 - i]);
        end
        for (i = 0; i < 8; i++)
            bits.push_back(POSTAMBLE[7 - i]);
        while (bits.size() < 102)
            bits.push_back(1'($urandom));
        if (flip >= 0)
            bits[flip] = ~bits[flip];
        for (i = 0; i < 102; i++)
        begin
            acc = {bits[i], acc[7:1]};
            if (i % 8 == 7 && flip < 0)
                exp_q.push_back(acc);
            fork
                src.send_bit(bits[i]);
                begin
                    #60;
                    if (flip < 0 && i > 0)
                        check("dout", 24'(expd), 24'(dout));
                    if (i >= 98 && i <= 100)
                        check("startup", flip < 0 ? 24'({i > 98, i > 99, 1'b0}) : 24'h0,
                            24'({done, io_en, rb_ok}));
                end
            join
            expd = (i < 36 || i >= 90) ? bits[i] : 1'b1;
        end
        src.release_line();
        repeat (20) @(negedge sys_clk);
        check("finish", flip < 0 ? 24'h7 : 24'h0, 24'({rb_ok, scan_ok, done}));
        check("init", flip >= 0 ? 24'h2 : 24'h0, 24'({init_oe, init_o}));
        if (flip < 0)
        begin
            check("length", LEN, length_count);
            check("fast", 24'(bits[41]), 24'(fast));
        end
    endtask
    initial
    begin
        void'($urandom(11));
        do_reset(1'b0);
        run(-1);
        foreach (flips[k])
        begin
            do_reset(1'b0);
            run(flips[k]);
        end
        do_reset(1'b1);
        repeat (400) @(negedge sys_clk);
        check("master_oe", 24'h1, 24'(config_clock_oe));
        report_and_stop;
    end
    // Watchdog against a hang.
    initial
    begin
        #200000;
        miscompares++;
        report_and_stop;
    end
endmodule
